// file: rtl/fcr_core.sv
// Channel fault response and retry logic with a classic Wishbone register slave.
`default_nettype none
// What this block does
// - Temperature fault sets byte summary and detail flags, input fault sets word and detail flags; alert goes low.
// - Action field 00b: channel keeps running through the fault.
// - Action 01b-11b: shut down now, or sequence off after turn-off delay if tracking.
// - After a fault shutdown the retry field decides whether to restart.
// - Retry field 000b: no restart, output stays disabled.
// - Nonzero retry: restart up to global count unless commanded off, unbiased or refaulted.
// - Retry fields and global count are sampled only when the channel is commanded on from off.
// - Deglitch field is fixed at 000b; faults act without filtering.
// - Startup timeout fault sets high-byte, output-voltage and timeout flags; alert goes low.
// - Retry interval is counted only in shared timebase ticks.
// - Effective retry interval is clamped to 13.1 seconds.
// - Effective retry interval is rounded to nearest 200 microseconds.
// - Retry interval reads back exactly what was written.
// - Global count 0 means none, 1-6 that many, 7 unlimited.
// - Retry budget restores after 6 s unfaulted, or on off-then-on command.
module fcr_core #(
   parameter int unsigned QUIET_CYCLES = fcr_pkg::QUIET_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic share_clk_i,
   input wire logic [4:0] fault_i,
   input wire logic on_cmd_i,
   input wire logic bias_ok_i,
   output logic chan_en_o,
   output logic seq_off_o,
   output logic turn_on_start_o,
   output logic host_alert_n_o,
   output logic irq_o,
   output var fcr_pkg::fcr_flags_t flags_o
);

   function automatic logic [4:0] resp_sel(input logic [7:0] a);
      resp_sel = {a == fcr_pkg::ADR_TON, a == fcr_pkg::ADR_VUV, a == fcr_pkg::ADR_VOV,
                  a == fcr_pkg::ADR_UT, a == fcr_pkg::ADR_OT};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
   endfunction

   logic [7:0] resp_cfg [0:4];
   logic [23:0] retry_delay;
   logic [2:0] retry_count;
   logic track_en;
   logic [15:0] off_delay;
   fcr_pkg::fcr_flags_t flags;
   fcr_pkg::fcr_flags_t flag_set;
   logic [7:0] evt;
   logic [7:0] evt_set;
   logic [7:0] mask;
   logic [31:0] rdata;
   logic [31:0] wm;
   logic [4:0] rsel;
   logic wb_hit;
   logic wr;
   logic rd;

   fcr_pkg::fcr_state_t st;
   fcr_pkg::fcr_state_t next_st;
   logic [4:0] act_nz;
   logic [4:0] rty_nz;
   logic [4:0] rty_snap;
   logic [4:0] trip;
   logic [4:0] cause;
   logic [4:0] fault_q;
   logic [2:0] retry_left;
   logic [2:0] cnt_snap;
   logic inf_snap;
   logic pend_retry;
   logic stop;
   logic trip_any;
   logic budget_ok;
   logic retry_go;
   logic other_fault;
   logic off_done;
   logic wait_done;
   logic restart;
   logic [31:0] quiet_cnt;
   logic [7:0] tick_cnt;
   logic [15:0] quanta_cnt;
   logic [15:0] off_cnt;
   logic [15:0] retry_quanta;
   logic [24:0] rnd_sum;
   logic [24:0] rnd_q;
   logic sh_meta;
   logic sh_sync;
   logic sh_prev;
   logic tick;

   // Register bus: one wait state, so ack rises on the edge after the request is seen.
   assign wb_hit = cyc_i & stb_i & ~ack_o;
   assign wr = wb_hit & we_i;
   assign rd = wb_hit & ~we_i;
   assign rsel = resp_sel(adr_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= wb_hit;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      for (int i = 0; i < fcr_pkg::NF; i++) begin
         if (rsel[i]) begin
            rdata = {24'h000000, resp_cfg[i]};
         end
      end
      case (adr_i)
         fcr_pkg::ADR_RDLY: rdata = {8'h00, retry_delay};
         fcr_pkg::ADR_RCNT: rdata = {29'h0000_0000, retry_count};
         fcr_pkg::ADR_CTRL: rdata = {31'h0000_0000, track_en};
         fcr_pkg::ADR_OFFDLY: rdata = {16'h0000, off_delay};
         fcr_pkg::ADR_FLAGS: rdata = {23'h000000, flags};
         fcr_pkg::ADR_EVT: rdata = {24'h000000, evt};
         fcr_pkg::ADR_MASK: rdata = {24'h000000, mask};
         fcr_pkg::ADR_STATE: rdata = {21'h000000, retry_left, 5'h00, st == fcr_pkg::ST_HOLD, seq_off_o, chan_en_o};
         default: ;
      endcase
   end

   assign wm = merge(rdata, dat_i, sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd) begin
         dat_o <= rdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < fcr_pkg::NF; i++) begin
            resp_cfg[i] <= fcr_pkg::RESP_RST;
         end
         retry_delay <= fcr_pkg::RDLY_RST;
         retry_count <= fcr_pkg::RCNT_RST;
         track_en <= fcr_pkg::CTRL_RST;
         off_delay <= fcr_pkg::OFFDLY_RST;
         mask <= fcr_pkg::MASK_RST;
      end else if (wr) begin
         for (int i = 0; i < fcr_pkg::NF; i++) begin
            if (rsel[i]) begin
               // The deglitch bits never store what was written.
               resp_cfg[i] <= {wm[fcr_pkg::ACT_HI:fcr_pkg::RTY_LO], fcr_pkg::DGL_FIXED};
            end
         end
         case (adr_i)
            fcr_pkg::ADR_RDLY: retry_delay <= wm[23:0];
            fcr_pkg::ADR_RCNT: retry_count <= wm[2:0];
            fcr_pkg::ADR_CTRL: track_en <= wm[0];
            fcr_pkg::ADR_OFFDLY: off_delay <= wm[15:0];
            fcr_pkg::ADR_MASK: mask <= wm[7:0];
            default: ;
         endcase
      end
   end

   // Status flags: hardware sets beat a same-cycle write-one-to-clear.
   always_comb begin
      flag_set = '0;
      flag_set.ot = fault_i[fcr_pkg::F_OT];
      flag_set.ut = fault_i[fcr_pkg::F_UT];
      flag_set.vin_ov = fault_i[fcr_pkg::F_VOV];
      flag_set.vin_uv = fault_i[fcr_pkg::F_VUV];
      flag_set.byte_temp = fault_i[fcr_pkg::F_OT] | fault_i[fcr_pkg::F_UT];
      flag_set.word_input = fault_i[fcr_pkg::F_VOV] | fault_i[fcr_pkg::F_VUV];
      flag_set.ton_max = fault_i[fcr_pkg::F_TON];
      flag_set.byte_high = fault_i[fcr_pkg::F_TON];
      flag_set.word_outv = fault_i[fcr_pkg::F_TON];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= '0;
      end else if (wr && adr_i == fcr_pkg::ADR_FLAGS) begin
         flags <= (flags & ~(dat_i[8:0] & {sel_i[1], {8{sel_i[0]}}})) | flag_set;
      end else begin
         flags <= flags | flag_set;
      end
   end

   assign flags_o = flags;
   assign host_alert_n_o = ~(|flags);

   // Shared timebase arrives from a pin; only the second stage feeds the edge detector.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_meta <= 1'b0;
         sh_sync <= 1'b0;
         sh_prev <= 1'b0;
      end else begin
         sh_meta <= share_clk_i;
         sh_sync <= sh_meta;
         sh_prev <= sh_sync;
      end
   end

   assign tick = sh_sync & ~sh_prev;

   // Rounded and clamped interval, recomputed from the stored value so readback stays untouched.
   assign rnd_sum = {1'b0, retry_delay} + 25'(fcr_pkg::RETRY_HALF_US);
   assign rnd_q = rnd_sum / 25'(fcr_pkg::RETRY_QUANTUM_US);
   assign retry_quanta = (rnd_q > 25'(fcr_pkg::RETRY_MAX_QUANTA)) ?
                         16'(fcr_pkg::RETRY_MAX_QUANTA) : rnd_q[15:0];

   for (genvar g = 0; g < fcr_pkg::NF; g++) begin : g_cfg
      assign act_nz[g] = resp_cfg[g][fcr_pkg::ACT_HI:fcr_pkg::ACT_LO] != fcr_pkg::ACT_CONTINUE;
      assign rty_nz[g] = resp_cfg[g][fcr_pkg::RTY_HI:fcr_pkg::RTY_LO] != fcr_pkg::RTY_NONE;
   end

   assign stop = ~on_cmd_i | ~bias_ok_i;
   assign trip = fault_i & act_nz;
   assign trip_any = |trip;
   assign budget_ok = inf_snap | (retry_left != 3'h0);
   // Any tripping fault whose retry field was zero at turn-on forbids the restart.
   assign retry_go = ((trip & ~rty_snap) == 5'h00) & budget_ok;
   assign other_fault = |(trip & ~cause);
   assign off_done = off_cnt >= off_delay;
   assign wait_done = quanta_cnt >= retry_quanta;
   assign restart = (st == fcr_pkg::ST_WAIT) & ~stop & ~other_fault & wait_done;

   always_comb begin
      next_st = st;
      unique case (st)
         fcr_pkg::ST_OFF: begin
            if (!stop) begin
               next_st = fcr_pkg::ST_ON;
            end
         end
         fcr_pkg::ST_ON: begin
            if (stop) begin
               next_st = fcr_pkg::ST_OFF;
            end else if (trip_any) begin
               next_st = track_en ? fcr_pkg::ST_OFFSEQ : (retry_go ? fcr_pkg::ST_WAIT : fcr_pkg::ST_HOLD);
            end
         end
         fcr_pkg::ST_OFFSEQ: begin
            if (stop) begin
               next_st = fcr_pkg::ST_OFF;
            end else if (off_done) begin
               next_st = (pend_retry && !other_fault) ? fcr_pkg::ST_WAIT : fcr_pkg::ST_HOLD;
            end
         end
         fcr_pkg::ST_WAIT: begin
            if (stop) begin
               next_st = fcr_pkg::ST_OFF;
            end else if (other_fault) begin
               next_st = fcr_pkg::ST_HOLD;
            end else if (wait_done) begin
               next_st = fcr_pkg::ST_ON;
            end
         end
         fcr_pkg::ST_HOLD: begin
            if (stop) begin
               next_st = fcr_pkg::ST_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= fcr_pkg::ST_OFF;
         chan_en_o <= 1'b0;
         seq_off_o <= 1'b0;
         turn_on_start_o <= 1'b0;
      end else begin
         st <= next_st;
         chan_en_o <= (next_st == fcr_pkg::ST_ON) || (next_st == fcr_pkg::ST_OFFSEQ);
         seq_off_o <= next_st == fcr_pkg::ST_OFFSEQ;
         turn_on_start_o <= (st != fcr_pkg::ST_ON) && (next_st == fcr_pkg::ST_ON);
      end
   end

   // Retry context: a mid-run write to the retry fields or global count waits for the next turn-on from off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rty_snap <= 5'h00;
         cnt_snap <= 3'h0;
         inf_snap <= 1'b0;
         retry_left <= 3'h0;
         cause <= 5'h00;
         pend_retry <= 1'b0;
      end else begin
         if (st == fcr_pkg::ST_OFF && next_st == fcr_pkg::ST_ON) begin
            rty_snap <= rty_nz;
            cnt_snap <= retry_count;
            inf_snap <= retry_count == fcr_pkg::RCNT_INFINITE;
            retry_left <= retry_count;
         end else if (st == fcr_pkg::ST_ON && !trip_any && quiet_cnt == 32'(QUIET_CYCLES - 1)) begin
            retry_left <= cnt_snap;
         end else if (restart && !inf_snap) begin
            retry_left <= retry_left - 3'h1;
         end
         if (st == fcr_pkg::ST_ON && trip_any) begin
            cause <= trip;
            pend_retry <= retry_go;
         end else if (st == fcr_pkg::ST_OFFSEQ && other_fault) begin
            pend_retry <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         quiet_cnt <= 32'h0000_0000;
      end else if (st != fcr_pkg::ST_ON || trip_any || quiet_cnt == 32'(QUIET_CYCLES - 1)) begin
         quiet_cnt <= 32'h0000_0000;
      end else begin
         quiet_cnt <= quiet_cnt + 32'h0000_0001;
      end
   end

   // Delay counters advance on shared ticks only, so all channels retry on a common beat.
   always_ff @(posedge clk_i) begin
      if (rst_i || st != next_st) begin
         tick_cnt <= 8'h00;
         quanta_cnt <= 16'h0000;
         off_cnt <= 16'h0000;
      end else if (tick) begin
         if (st == fcr_pkg::ST_OFFSEQ && !off_done) begin
            off_cnt <= off_cnt + 16'h0001;
         end
         if (st == fcr_pkg::ST_WAIT) begin
            if (tick_cnt == fcr_pkg::SHARE_TICKS_PER_QUANTUM - 8'h01) begin
               tick_cnt <= 8'h00;
               if (!wait_done) begin
                  quanta_cnt <= quanta_cnt + 16'h0001;
               end
            end else begin
               tick_cnt <= tick_cnt + 8'h01;
            end
         end
      end
   end

   // Interrupt events: sticky, cleared by reading the event register, a new event wins.
   always_comb begin
      evt_set = 8'h00;
      evt_set[4:0] = fault_i & ~fault_q;
      evt_set[fcr_pkg::EV_SHUT] = (st == fcr_pkg::ST_ON) && !stop && trip_any;
      evt_set[fcr_pkg::EV_RESTART] = restart;
      evt_set[fcr_pkg::EV_HOLD] = (next_st == fcr_pkg::ST_HOLD) && (st != fcr_pkg::ST_HOLD);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_q <= 5'h00;
         evt <= 8'h00;
      end else begin
         fault_q <= fault_i;
         evt <= (evt & ~{8{rd && adr_i == fcr_pkg::ADR_EVT}}) | evt_set;
      end
   end

   assign irq_o = |(evt & mask);

   sequence s_seq_off;
      seq_off_o && chan_en_o;
   endsequence

   sequence s_restart;
      chan_en_o && turn_on_start_o ##1 !turn_on_start_o;
   endsequence

   property p_temp_flags;
      @(posedge clk_i) disable iff (rst_i) fault_i[fcr_pkg::F_OT] |=> flags.ot && flags.byte_temp && !host_alert_n_o;
   endproperty
   a_temp_flags: assert property (p_temp_flags) else $error("temperature fault did not set flags");

   property p_continue;
      @(posedge clk_i) disable iff (rst_i)
         (st == fcr_pkg::ST_ON && !stop && (|fault_i) && !trip_any) |=> chan_en_o;
   endproperty
   a_continue: assert property (p_continue) else $error("channel stopped on a continue fault");

   property p_shut_now;
      @(posedge clk_i) disable iff (rst_i)
         (st == fcr_pkg::ST_ON && !stop && trip_any && !track_en) |=> !chan_en_o && !seq_off_o;
   endproperty
   a_shut_now: assert property (p_shut_now) else $error("channel not shut down at once");

   property p_track_off;
      @(posedge clk_i) disable iff (rst_i)
         (st == fcr_pkg::ST_ON && !stop && trip_any && track_en) |=> s_seq_off;
   endproperty
   a_track_off: assert property (p_track_off) else $error("tracking channel did not sequence off");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i) (st == fcr_pkg::ST_HOLD && !stop) |=> st == fcr_pkg::ST_HOLD && !chan_en_o;
   endproperty
   a_hold: assert property (p_hold) else $error("held channel restarted");

   property p_stop;
      @(posedge clk_i) disable iff (rst_i) stop |=> !chan_en_o && !turn_on_start_o;
   endproperty
   a_stop: assert property (p_stop) else $error("channel on while commanded off");

   property p_budget;
      @(posedge clk_i) disable iff (rst_i) (st == fcr_pkg::ST_WAIT) |-> (inf_snap || retry_left != 3'h0);
   endproperty
   a_budget: assert property (p_budget) else $error("waiting to retry with no budget");

   property p_deglitch;
      @(posedge clk_i) disable iff (rst_i) (ack_o && !we_i && (|rsel)) |-> dat_o[2:0] == fcr_pkg::DGL_FIXED;
   endproperty
   a_deglitch: assert property (p_deglitch) else $error("deglitch field not zero");

   property p_ton_flags;
      @(posedge clk_i) disable iff (rst_i)
         fault_i[fcr_pkg::F_TON] |=> flags.ton_max && flags.byte_high && flags.word_outv && !host_alert_n_o;
   endproperty
   a_ton_flags: assert property (p_ton_flags) else $error("timeout fault did not set flags");

   property p_tick_only;
      @(posedge clk_i) disable iff (rst_i) (!tick && st == next_st) |=> $stable(quanta_cnt);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("retry interval moved without a tick");

   property p_clamp;
      @(posedge clk_i) disable iff (rst_i) retry_quanta <= 16'(fcr_pkg::RETRY_MAX_QUANTA);
   endproperty
   a_clamp: assert property (p_clamp) else $error("retry interval above limit");

   property p_readback;
      @(posedge clk_i) disable iff (rst_i)
         (ack_o && !we_i && adr_i == fcr_pkg::ADR_RDLY) |-> dat_o == {8'h00, retry_delay};
   endproperty
   a_readback: assert property (p_readback) else $error("retry interval readback altered");

   property p_restart;
      @(posedge clk_i) disable iff (rst_i) restart |=> s_restart;
   endproperty
   a_restart: assert property (p_restart) else $error("channel not restarted after interval");

   property p_decrement;
      @(posedge clk_i) disable iff (rst_i) (restart && !inf_snap) |=> retry_left == $past(retry_left) - 3'h1;
   endproperty
   a_decrement: assert property (p_decrement) else $error("retry budget not decremented");

endmodule
`default_nettype wire

// file: rtl/fcr_pkg.sv
// Register map, field layout, timing constants and types of the channel fault response block.
`default_nettype none
package fcr_pkg;
   // Byte addresses on the register bus.
   localparam logic [7:0] ADR_OT = 8'h00;
   localparam logic [7:0] ADR_UT = 8'h04;
   localparam logic [7:0] ADR_VOV = 8'h08;
   localparam logic [7:0] ADR_VUV = 8'h0c;
   localparam logic [7:0] ADR_TON = 8'h10;
   localparam logic [7:0] ADR_RDLY = 8'h14;
   localparam logic [7:0] ADR_RCNT = 8'h18;
   localparam logic [7:0] ADR_CTRL = 8'h1c;
   localparam logic [7:0] ADR_OFFDLY = 8'h20;
   localparam logic [7:0] ADR_FLAGS = 8'h24;
   localparam logic [7:0] ADR_EVT = 8'h28;
   localparam logic [7:0] ADR_MASK = 8'h2c;
   localparam logic [7:0] ADR_STATE = 8'h30;

   // Fault response byte layout.
   localparam int ACT_HI = 7;
   localparam int ACT_LO = 6;
   localparam int RTY_HI = 5;
   localparam int RTY_LO = 3;
   localparam logic [2:0] DGL_FIXED = 3'h0;
   localparam logic [1:0] ACT_CONTINUE = 2'h0;
   localparam logic [2:0] RTY_NONE = 3'h0;
   localparam logic [2:0] RCNT_INFINITE = 3'h7;

   // Fault inputs and event bits.
   localparam int NF = 5;
   localparam int F_OT = 0;
   localparam int F_UT = 1;
   localparam int F_VOV = 2;
   localparam int F_VUV = 3;
   localparam int F_TON = 4;
   localparam int EV_SHUT = 5;
   localparam int EV_RESTART = 6;
   localparam int EV_HOLD = 7;

   // Reset values.
   localparam logic [7:0] RESP_RST = 8'h00;
   localparam logic [23:0] RDLY_RST = 24'h000000;
   localparam logic [2:0] RCNT_RST = 3'h0;
   localparam logic CTRL_RST = 1'b0;
   localparam logic [15:0] OFFDLY_RST = 16'h0000;
   localparam logic [7:0] MASK_RST = 8'h00;

   // Timing.
   localparam int CLK_HZ = 25_000_000;
   localparam int QUIET_S = 6;
   localparam int QUIET_CYCLES = QUIET_S * CLK_HZ;
   localparam int RETRY_QUANTUM_US = 200;
   localparam int RETRY_HALF_US = RETRY_QUANTUM_US / 2;
   localparam int RETRY_MAX_US = 13_100_000;
   localparam int RETRY_MAX_QUANTA = RETRY_MAX_US / RETRY_QUANTUM_US;
   localparam logic [7:0] SHARE_TICKS_PER_QUANTUM = 8'h14;

   typedef struct packed {
      logic byte_temp;
      logic byte_high;
      logic word_input;
      logic word_outv;
      logic ot;
      logic ut;
      logic vin_ov;
      logic vin_uv;
      logic ton_max;
   } fcr_flags_t;

   typedef enum logic [2:0] {ST_OFF, ST_ON, ST_OFFSEQ, ST_WAIT, ST_HOLD} fcr_state_t;
endpackage
`default_nettype wire

// file: sim/fcr_share_src.sv
// Shared timebase source standing at the far side of the channel block.
`default_nettype none
module fcr_share_src #(
   parameter int HALF = 4
) (
   input wire logic clk_i,
   input wire logic run_i,
   output logic share_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial share_clk_o = 1'b0;
   // The timebase free-runs while enabled, so tick spacing is exactly 2*HALF clocks.
   always @(posedge clk_i) begin
      if (run_i) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) share_clk_o <= ~share_clk_o;
      end
   end
endmodule
`default_nettype wire

// file: sim/test_channel_fault_response_retry.sv
// Self-checking bench of the channel fault response and retry block.
`default_nettype none
module test_channel_fault_response_retry;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, on = 0, bias = 1, shr, run = 1;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] wd = 0, rd, q;
   logic ack, en, soff, tos, alert_n, irq;
   logic [4:0] flt = 0;
   fcr_pkg::fcr_flags_t fl;
   int n_fail = 0, total_checks = 0, n;
   logic [7:0] ra [5] = '{fcr_pkg::ADR_OT, fcr_pkg::ADR_RDLY, fcr_pkg::ADR_RCNT, 8'h3c, fcr_pkg::ADR_MASK};
   logic [31:0] rw [5] = '{32'hff, 32'hffffffff, 32'hff, 32'hff, 32'hff};
   logic [31:0] rx [5] = '{32'hf8, 32'hffffff, 32'h7, 32'h0, 32'hff};
   always #20 clk_i = ~clk_i;
   fcr_share_src #(.HALF(4)) i_fcr_share_src (.clk_i(clk_i), .run_i(run), .share_clk_o(shr));
   fcr_core #(.QUIET_CYCLES(200)) i_fcr_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .share_clk_i(shr),
      .fault_i(flt), .on_cmd_i(on), .bias_ok_i(bias), .chan_en_o(en), .seq_off_o(soff),
      .turn_on_start_o(tos), .host_alert_n_o(alert_n), .irq_o(irq), .flags_o(fl));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Classic single cycle: request held until ack is sampled high, then released.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rd;
      cyc <= 0; stb <= 0; we <= 0;
      if (k >= 50) begin
         chk("bus ack", 1, 0);
         give_verdict();
      end
   endtask
   task automatic fp(input int i);
      @(posedge clk_i);
      flt <= 5'h1 << i;
      @(posedge clk_i);
      flt <= 0;
      #1;
   endtask
   task automatic wt();
      n = 0;
      while (tos !== 1'b1 && n < 1000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 1000) begin
         chk("restart wait", 1, 0);
         give_verdict();
      end
   endtask
   task automatic recycle();
      @(posedge clk_i);
      on <= 0;
      repeat (3) @(posedge clk_i);
      on <= 1;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      #1;
      chk("alert_n", 1, alert_n);
      chk("flags", 0, fl);
      chk("chan_en", 0, en);
      $display("reset test done");
      for (int i = 0; i < 5; i++) begin
         wb(1, ra[i], rw[i]);
         wb(0, ra[i], 0);
         chk("readback", rx[i], q);
      end
      $display("register table done");
      wb(1, fcr_pkg::ADR_OT, 0);
      wb(1, fcr_pkg::ADR_RDLY, 299);
      wb(1, fcr_pkg::ADR_RCNT, 1);
      wb(1, fcr_pkg::ADR_TON, 8'h48);
      wb(1, fcr_pkg::ADR_UT, 8'h40);
      recycle();
      wb(0, fcr_pkg::ADR_EVT, 0);
      chk("on", 1, en);
      fp(fcr_pkg::F_OT);
      chk("continue", 1, en);
      chk("ot", 1, fl.ot & fl.byte_temp);
      chk("alert_n", 0, alert_n);
      chk("irq", 1, irq);
      wb(0, fcr_pkg::ADR_EVT, 0);
      chk("event", 1, q[fcr_pkg::F_OT]);
      chk("irq clr", 0, irq);
      wb(1, fcr_pkg::ADR_FLAGS, 32'h1ff);
      chk("alert_n clr", 1, alert_n);
      $display("continue test done");
      fp(fcr_pkg::F_TON);
      chk("ton flags", 1, fl.ton_max & fl.word_outv & fl.byte_high);
      chk("shut", 0, en);
      wt();
      chk("interval", 1, n >= 150 && n <= 200);
      wb(0, fcr_pkg::ADR_STATE, 0);
      chk("left", 0, q[10:8]);
      repeat (300) @(posedge clk_i);
      fp(fcr_pkg::F_TON);
      wt();
      chk("restored", 1, n < 1000);
      @(posedge clk_i);
      fp(fcr_pkg::F_TON);
      repeat (400) @(posedge clk_i);
      #1;
      chk("spent", 0, en);
      wb(0, fcr_pkg::ADR_STATE, 0);
      chk("hold", 1, q[2]);
      $display("retry test done");
      recycle();
      chk("off on", 1, en);
      fp(fcr_pkg::F_UT);
      repeat (400) @(posedge clk_i);
      #1;
      chk("no retry", 0, en);
      wb(1, fcr_pkg::ADR_CTRL, 1);
      wb(1, fcr_pkg::ADR_OFFDLY, 2);
      wb(1, fcr_pkg::ADR_OT, 8'h40);
      recycle();
      fp(fcr_pkg::F_OT);
      chk("seq off", 1, soff & en);
      n = 0;
      while (en !== 1'b0 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk("seq done", 1, n < 200);
      recycle();
      @(posedge clk_i);
      bias <= 0;
      repeat (2) @(posedge clk_i);
      #1;
      chk("bias loss", 0, en);
      $display("tracking test done");
      give_verdict();
   end
endmodule
`default_nettype wire
